// file: hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync
    import reset_cause_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic pin,
    output logic level
);

    sync_state_s q;
    sync_state_s s;

    // -----------------------------------------------------------
    // Three stages; the level only moves once stages two and three
    // agree, so a single sampled glitch never reaches the flags.
    // -----------------------------------------------------------
    always_comb begin
        s = q;
        s.shift = {q.shift[1:0], pin};
        if (q.shift[1] == q.shift[2]) begin
            s.level = q.shift[2];
        end
        if (rst) begin
            s.shift = 3'h0;
            s.level = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (ce) begin
            q <= s;
        end
    end

    assign level = q.level;

endmodule

// file: hdl/reset_cause_defs.svh
`ifndef RESET_CAUSE_DEFS_SVH
`define RESET_CAUSE_DEFS_SVH

// ---------------------------------------------------------------
// Register word indices; the byte address is four times the index.
// ---------------------------------------------------------------
`define IDX_POWER_CONTROL 8'h30
`define IDX_DOG_FEED 8'hA6
`define IDX_DOG_CONTROL 8'hA7
`define WB_IDX_MSB 9
`define WB_IDX_LSB 2

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define PWR_BROWNOUT_BIT 5
`define PWR_POWER_ON_BIT 4
`define PWR_GEN_MSB 3
`define PWR_GEN_LSB 0
`define DOG_OVF_BIT 5
`define DOG_RUN_BIT 4
`define DOG_CLK_BIT 3
`define DOG_SEL_MSB 2
`define DOG_SEL_LSB 0
`define DOG_DEF_MSB 5
`define CFG_PORT_HIGH_BIT 1

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define PWR_GEN_RESET 4'h0
`define DOG_DISABLED_RESET 8'h00
`define DOG_RESET_VALUE_DEF 8'h3C
`define DOG_ENABLED_VALUE_DEF 8'h1C
`define RDATA_RESET 32'h0000_0000
`define FEED_RESET 8'h00

`endif

// file: hdl/reset_cause_flags.sv
// Functional notes
// - Unimplemented register bits read as zero, their reset value.
// - During reset the port level follows the config byte port-high bit.
// - Reset clears power control low four bits; top two stay unused.
// - Brownout and power-on flags are untouched by any reset.
// - Power-up sets the power-on flag.
// - Brownout event or power-up sets the brownout flag.
// - Dog control loads one value on dog reset, another if enabled.
// - Non-dog reset with dog disabled clears the six defined bits.
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/1ns
`include "reset_cause_defs.svh"
module reset_cause_flags
    import reset_cause_pkg::*;
#(
    parameter logic [7:0] DOG_RESET_VALUE = `DOG_RESET_VALUE_DEF,
    parameter logic [7:0] DOG_ENABLED_VALUE = `DOG_ENABLED_VALUE_DEF
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic power_up,
    input wire logic brownout_pin,
    input wire logic dog_reset,
    input wire logic dog_enable,
    input wire logic [7:0] user_config_byte_one,
    output logic port_reset_level,
    output logic dog_run_enable,
    output logic dog_clock_select,
    output logic [2:0] dog_period_sel,
    output logic dog_feed_strobe,
    output logic [7:0] dog_feed_data
);

    flags_state_s q;
    flags_state_s s;
    logic brownout_level;
    logic bus_req;
    logic bus_wr;
    logic [7:0] idx;
    logic [7:0] dog_load;

    // ---------------------------------------------------------------
    // Brownout detector input
    // ---------------------------------------------------------------
    pin_sync brownout_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin(brownout_pin),
        .level(brownout_level)
    );

    // ---------------------------------------------------------------
    // Register bus and flag logic
    // ---------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign idx = wb_adr_i[`WB_IDX_MSB:`WB_IDX_LSB];
    // Writes land on the edge where ack is seen high, as the master expects.
    assign bus_wr = bus_req & wb_we_i & q.ack & wb_sel_i[0];

    always_comb begin
        dog_load = `DOG_DISABLED_RESET;
        if (dog_reset) begin
            dog_load = DOG_RESET_VALUE;
        end else if (dog_enable) begin
            dog_load = DOG_ENABLED_VALUE;
        end
    end

    always_comb begin
        s = q;
        s.brownout_prev = brownout_level;
        s.ack = bus_req & ~q.ack;
        s.feed = 1'b0;
        if (bus_req & ~q.ack) begin
            unique case (idx)
                `IDX_POWER_CONTROL: begin
                    s.rdata = `RDATA_RESET;
                    s.rdata[`PWR_BROWNOUT_BIT] = q.brownout_flag;
                    s.rdata[`PWR_POWER_ON_BIT] = q.power_on_flag;
                    s.rdata[`PWR_GEN_MSB:`PWR_GEN_LSB] = q.power_general;
                end
                `IDX_DOG_CONTROL: begin
                    s.rdata = `RDATA_RESET;
                    s.rdata[`DOG_OVF_BIT] = q.dog_overflow_flag;
                    s.rdata[`DOG_RUN_BIT] = q.dog_run_enable;
                    s.rdata[`DOG_CLK_BIT] = q.dog_clock_select;
                    s.rdata[`DOG_SEL_MSB:`DOG_SEL_LSB] = q.dog_period_sel;
                end
                default: begin
                    s.rdata = `RDATA_RESET;
                end
            endcase
        end
        if (bus_wr && idx == `IDX_DOG_FEED) begin
            s.feed = 1'b1;
            s.feed_data = wb_dat_i[7:0];
        end
        // Bits above the defined fields are simply dropped on write.
        if (bus_wr && idx == `IDX_POWER_CONTROL) begin
            s.brownout_flag = wb_dat_i[`PWR_BROWNOUT_BIT];
            s.power_on_flag = wb_dat_i[`PWR_POWER_ON_BIT];
            s.power_general = wb_dat_i[`PWR_GEN_MSB:`PWR_GEN_LSB];
        end
        if (bus_wr && idx == `IDX_DOG_CONTROL) begin
            s.dog_overflow_flag = wb_dat_i[`DOG_OVF_BIT];
            s.dog_run_enable = wb_dat_i[`DOG_RUN_BIT];
            s.dog_clock_select = wb_dat_i[`DOG_CLK_BIT];
            s.dog_period_sel = wb_dat_i[`DOG_SEL_MSB:`DOG_SEL_LSB];
        end
        if (rst) begin
            // The brownout and power-on flags are left alone here on purpose.
            s.ack = 1'b0;
            s.rdata = `RDATA_RESET;
            s.feed = 1'b0;
            s.feed_data = `FEED_RESET;
            s.power_general = `PWR_GEN_RESET;
            s.port_reset_high = user_config_byte_one[`CFG_PORT_HIGH_BIT];
            s.dog_overflow_flag = dog_load[`DOG_OVF_BIT];
            s.dog_run_enable = dog_load[`DOG_RUN_BIT];
            s.dog_clock_select = dog_load[`DOG_CLK_BIT];
            s.dog_period_sel = dog_load[`DOG_SEL_MSB:`DOG_SEL_LSB];
        end
        // Hardware events come last so they win over a software clear.
        if (brownout_level & ~q.brownout_prev) begin
            s.brownout_flag = 1'b1;
        end
        if (power_up) begin
            s.power_on_flag = 1'b1;
            s.brownout_flag = 1'b1;
        end
        if (dog_reset) begin
            s.dog_overflow_flag = 1'b1;
        end
    end

    // A low clock enable freezes everything, reset included.
    always_ff @(posedge clk) begin
        if (ce) begin
            q <= s;
        end
    end

    assign wb_ack_o = q.ack;
    assign wb_dat_o = q.rdata;
    assign port_reset_level = q.port_reset_high;
    assign dog_run_enable = q.dog_run_enable;
    assign dog_clock_select = q.dog_clock_select;
    assign dog_period_sel = q.dog_period_sel;
    assign dog_feed_strobe = q.feed;
    assign dog_feed_data = q.feed_data;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence reset_left;
        $fell(rst) && $past(ce);
    endsequence

    sequence read_answered;
        ##1 q.ack;
    endsequence

    chk_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        q.ack && ce |=> !q.ack)
        else $error("ack held longer than one cycle");

    chk_read_zero_top: assert property (@(posedge clk) disable iff (rst)
        bus_req && !q.ack && !wb_we_i && ce && idx == `IDX_POWER_CONTROL
        |-> read_answered ##0 (wb_dat_o[31:6] == 26'h0))
        else $error("unimplemented bits read nonzero");

    chk_port_level: assert property (@(posedge clk) disable iff (1'b0)
        rst && ce |=> port_reset_level == $past(user_config_byte_one[`CFG_PORT_HIGH_BIT]))
        else $error("port reset level does not follow config");

    chk_power_low_clr: assert property (@(posedge clk) disable iff (1'b0)
        reset_left |-> q.power_general == 4'h0)
        else $error("power control low bits not cleared");

    chk_flags_keep: assert property (@(posedge clk) disable iff (1'b0)
        rst && ce && !power_up && !bus_wr && !(brownout_level & ~q.brownout_prev)
        |=> q.brownout_flag == $past(q.brownout_flag)
            && q.power_on_flag == $past(q.power_on_flag))
        else $error("reset disturbed a cause flag");

    chk_power_on_set: assert property (@(posedge clk) disable iff (1'b0)
        power_up && ce |=> q.power_on_flag && q.brownout_flag)
        else $error("power-up did not set flags");

    chk_brownout_set: assert property (@(posedge clk) disable iff (1'b0)
        $rose(brownout_level) && ce |=> q.brownout_flag)
        else $error("brownout did not set flag");

    chk_dog_reset_val: assert property (@(posedge clk) disable iff (1'b0)
        rst && ce && dog_reset |=> dog_run_enable == DOG_RESET_VALUE[`DOG_RUN_BIT]
            && dog_period_sel == DOG_RESET_VALUE[`DOG_SEL_MSB:`DOG_SEL_LSB])
        else $error("dog control wrong after dog reset");

    chk_dog_enabled_val: assert property (@(posedge clk) disable iff (1'b0)
        rst && ce && !dog_reset && dog_enable
        |=> dog_clock_select == DOG_ENABLED_VALUE[`DOG_CLK_BIT]
            && dog_period_sel == DOG_ENABLED_VALUE[`DOG_SEL_MSB:`DOG_SEL_LSB])
        else $error("dog control wrong after enabled reset");

    chk_dog_disabled_val: assert property (@(posedge clk) disable iff (1'b0)
        rst && ce && !dog_reset && !dog_enable
        |=> !q.dog_overflow_flag && !dog_run_enable && !dog_clock_select
            && dog_period_sel == 3'h0)
        else $error("dog control not cleared after disabled reset");

    chk_overflow_set: assert property (@(posedge clk) disable iff (1'b0)
        dog_reset && ce |=> q.dog_overflow_flag)
        else $error("dog reset did not set overflow flag");

endmodule

// file: hdl/reset_cause_pkg.sv
package reset_cause_pkg;

    typedef struct packed {
        logic [2:0] shift;
        logic level;
    } sync_state_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic brownout_flag;
        logic power_on_flag;
        logic [3:0] power_general;
        logic dog_overflow_flag;
        logic dog_run_enable;
        logic dog_clock_select;
        logic [2:0] dog_period_sel;
        logic port_reset_high;
        logic feed;
        logic [7:0] feed_data;
        logic brownout_prev;
    } flags_state_s;

endpackage

// file: testbench/tb_reset_cause_flags.sv
`timescale 1ns/1ns
`include "reset_cause_defs.svh"
module tb_reset_cause_flags;
    import reset_cause_pkg::*;
    // ---------------------------------------------------------------
    // Stimulus and design.
    // ---------------------------------------------------------------
    typedef struct packed {logic we; logic [7:0] idx; logic [7:0] dat;} row_s;
    logic clk, rst, ce, cyc, stb, we, power_up, brownout_pin, dog_reset, dog_enable;
    logic [3:0] sel;
    logic [31:0] adr, wdat, rdat_o, rd;
    logic ack, port_level, run, clk_sel, strobe;
    logic [2:0] period;
    logic [7:0] cfg, feed_data;
    int err_count = 0;
    int comparisons = 0;
    int hits;
    row_s rows [9];
    reset_cause_flags DUT (.clk(clk), .rst(rst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat_o),
        .wb_ack_o(ack), .power_up(power_up), .brownout_pin(brownout_pin),
        .dog_reset(dog_reset), .dog_enable(dog_enable), .user_config_byte_one(cfg),
        .port_reset_level(port_level), .dog_run_enable(run), .dog_clock_select(clk_sel),
        .dog_period_sel(period), .dog_feed_strobe(strobe), .dog_feed_data(feed_data));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (err_count == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Bus cycle: ack and read data are taken at the rising edge that
    // samples ack high, and the request is released at that same edge.
    // ---------------------------------------------------------------
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d,
                        output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {22'h0, idx, 2'h0};
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        r = rdat_o;
        if (ack !== 1'b1) chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00, rd);
        chk(what, {24'h0, exp}, rd);
    endtask
    // Holds reset six cycles; power_up held through all six keeps the flags defined.
    task automatic do_reset(input logic pu, input logic dr, input logic de, input logic [7:0] c);
        @(posedge clk);
        rst <= 1'b1;
        power_up <= pu;
        dog_reset <= dr;
        dog_enable <= de;
        cfg <= c;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        power_up <= 1'b0;
        dog_reset <= 1'b0;
        @(negedge clk);
        chk("port_reset_level", {31'h0, c[`CFG_PORT_HIGH_BIT]}, {31'h0, port_level});
    endtask
    initial begin
        #400000;
        chk("timeout", 32'h0, 32'h1);
        end_sim();
    end
    initial begin
        {rst, cyc, stb, we, power_up, brownout_pin, dog_reset, dog_enable} = '0;
        ce = 1'b1;
        sel = 4'h1;
        adr = '0;
        wdat = '0;
        cfg = 8'h00;
        rows = '{'{1'b0, `IDX_POWER_CONTROL, 8'h30}, '{1'b1, `IDX_POWER_CONTROL, 8'h3F},
                 '{1'b0, `IDX_POWER_CONTROL, 8'h3F}, '{1'b1, `IDX_POWER_CONTROL, 8'h35},
                 '{1'b0, `IDX_POWER_CONTROL, 8'h35}, '{1'b1, `IDX_DOG_CONTROL, 8'h1B},
                 '{1'b0, `IDX_DOG_CONTROL, 8'h1B}, '{1'b0, `IDX_DOG_FEED, 8'h00},
                 '{1'b0, 8'h00, 8'h00}};
        do_reset(1'b1, 1'b0, 1'b0, 8'h02);
        chk("dog_fields", 32'h0, {27'h0, run, clk_sel, period});
        // Row 0 checks both flags set by power-up; unused bits never write ones.
        foreach (rows[i]) begin
            xfer(rows[i].we, rows[i].idx, rows[i].dat, rd);
            if (!rows[i].we) chk("row_read", {24'h0, rows[i].dat}, rd);
        end
        chk("dog_outputs", 32'h1B, {27'h0, run, clk_sel, period});
        // Ordinary reset keeps the flags but clears the general bits.
        do_reset(1'b0, 1'b0, 1'b0, 8'hFD);
        rd_chk("pwr_after_reset", `IDX_POWER_CONTROL, 8'h30);
        rd_chk("dog_disabled", `IDX_DOG_CONTROL, `DOG_DISABLED_RESET);
        xfer(1'b1, `IDX_POWER_CONTROL, 8'h00, rd);
        @(posedge clk);
        brownout_pin <= 1'b1;
        repeat (10) @(posedge clk);
        rd_chk("brownout_set", `IDX_POWER_CONTROL, 8'h20);
        do_reset(1'b0, 1'b1, 1'b0, 8'h00);
        rd_chk("dog_reset_val", `IDX_DOG_CONTROL, `DOG_RESET_VALUE_DEF | 8'h20);
        rd_chk("pwr_kept", `IDX_POWER_CONTROL, 8'h20);
        do_reset(1'b0, 1'b0, 1'b1, 8'h02);
        rd_chk("dog_enabled_val", `IDX_DOG_CONTROL, `DOG_ENABLED_VALUE_DEF);
        // The feed strobe is a single pulse carrying the written byte.
        xfer(1'b1, `IDX_DOG_FEED, 8'h5A, rd);
        hits = 0;
        repeat (3) begin
            @(negedge clk);
            if (strobe === 1'b1) hits++;
        end
        chk("feed_pulses", 32'h1, hits);
        chk("feed_data", 32'h5A, {24'h0, feed_data});
        // A low clock enable freezes the flags even while power_up is high.
        @(posedge clk);
        ce <= 1'b0;
        power_up <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        power_up <= 1'b0;
        rd_chk("ce_freeze", `IDX_POWER_CONTROL, 8'h20);
        // A power-up that meets a software clear wins over it.
        power_up <= 1'b1;
        xfer(1'b1, `IDX_POWER_CONTROL, 8'h00, rd);
        power_up <= 1'b0;
        rd_chk("set_wins", `IDX_POWER_CONTROL, 8'h30);
        // A write with the low byte lane off is acked but changes nothing.
        sel <= 4'h0;
        xfer(1'b1, `IDX_POWER_CONTROL, 8'h00, rd);
        sel <= 4'h1;
        rd_chk("sel_ignored", `IDX_POWER_CONTROL, 8'h30);
        end_sim();
    end
endmodule
